// ---- rtl/nip_top.sv ----
/*
 * nested interrupt priority controller: condition-code priority bits,
 * vector priority registers over apb, arbitration and interrupt entry.
 * assumes a cpu core that signals instruction ends and priority-changing
 * instructions, and peripherals that pulse their request set lines.
 */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

module nip_top
    import nip_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire nip_cpu_cmd_t           cpu_cmd,
    input  wire logic                   tli_pin,
    input  wire logic [NUM_PAIRS-1:0]   src_set,
    input  wire logic [NUM_PAIRS-1:0]   src_clr,
    input  wire logic [NUM_PAIRS-1:0]   src_enable,
    output logic      [7:0]             condition_code,
    output nip_take_t                   take,
    output logic      [NUM_PAIRS-1:0]   src_ack,
    output logic                        halted,
    output logic                        halt_wake
);

    // ****************************************
    // declarations
    // ****************************************
    nip_state_t             state;
    logic [1:0]             push_cnt;
    logic [NUM_PAIRS-1:0]   pend;
    logic                   trap_pend;
    logic                   tli_s1;
    logic                   tli_s2;
    logic                   tli_s3;
    logic                   tli_edge;
    logic [31:0]            prio_bus;
    logic [2*NUM_PAIRS-1:0] pairs;
    logic                   win_valid;
    logic                   win_nmi;
    logic                   win_trap;
    logic [3:0]             win_idx;
    logic                   sel_nmi;
    logic                   sel_trap;
    logic [3:0]             sel_idx;
    logic [2:0]             rsel;
    logic                   setup;
    logic                   wr_fire;
    logic                   prio_we;
    logic                   cc_we;
    logic                   take_now;
    logic [1:0]             cur_lvl;
    logic [NUM_PAIRS-1:0]   ack_now;
    logic [7:0]             next_cc;

    // decode: 0..3 priority register, 4 condition code, 7 unmapped
    function automatic logic [2:0] reg_decode(input logic [7:0] a);
        if (a == byte_addr(IDX_PRIO0)) begin
            reg_decode = 3'h0;
        end else if (a == byte_addr(IDX_PRIO1)) begin
            reg_decode = 3'h1;
        end else if (a == byte_addr(IDX_PRIO2)) begin
            reg_decode = 3'h2;
        end else if (a == byte_addr(IDX_PRIO3)) begin
            reg_decode = 3'h3;
        end else if (a == byte_addr(IDX_CC)) begin
            reg_decode = 3'h4;
        end else begin
            reg_decode = 3'h7;
        end
    endfunction

    // ****************************************
    // apb slave, no wait states
    // ****************************************
    assign rsel    = reg_decode(paddr);
    assign setup   = psel && !penable;
    assign wr_fire = psel && penable && pready && pwrite && !pslverr;
    assign prio_we = wr_fire && !rsel[2];
    assign cc_we   = wr_fire && (rsel == 3'h4);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && (rsel == 3'h7);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            unique case (rsel)
                3'h0, 3'h1, 3'h2, 3'h3: prdata <= {24'h000000, prio_bus[8*rsel[1:0] +: 8]};
                3'h4:                   prdata <= {24'h000000, condition_code};
                default:                prdata <= 32'h0000_0000;
            endcase
        end
    end

    nip_prio_regs u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (prio_we),
        .wr_idx  (rsel[1:0]),
        .wr_data (pwdata[7:0]),
        .regs    (prio_bus)
    );

    assign pairs = prio_bus[2*NUM_PAIRS-1:0];

    // ****************************************
    // source latches
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tli_s1 <= 1'b0;
            tli_s2 <= 1'b0;
            tli_s3 <= 1'b0;
        end else begin
            tli_s1 <= tli_pin;
            tli_s2 <= tli_s1;
            tli_s3 <= tli_s2;
        end
    end

    assign tli_edge = tli_s2 && !tli_s3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= '0;
        end else begin
            // a new request beats a clear in the same cycle
            pend <= (pend & ~(src_clr | ack_now)) | {src_set[NUM_PAIRS-1:1], tli_edge};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_pend <= 1'b0;
        end else if (cpu_cmd.trap && cpu_cmd.instr_end) begin
            trap_pend <= 1'b1;
        end else if (take_now && sel_trap) begin
            trap_pend <= 1'b0;
        end
    end

    // ****************************************
    // arbitration
    // ****************************************
    assign cur_lvl = {condition_code[CC_I1], condition_code[CC_I0]};

    nip_arbiter #(
        .N (NUM_PAIRS)
    ) u_arb (
        .cur_lvl   (cur_lvl),
        .pend      (pend),
        .enable    (src_enable | {{(NUM_PAIRS-1){1'b0}}, 1'b1}),
        .pairs     (pairs),
        .halted    (halted),
        .trap_pend (trap_pend),
        .win_valid (win_valid),
        .win_nmi   (win_nmi),
        .win_trap  (win_trap),
        .win_idx   (win_idx)
    );

    // ****************************************
    // entry sequence
    // ****************************************
    assign take_now = (state == ST_FETCH);
    assign ack_now  = (take_now && !sel_trap) ? NUM_PAIRS'(1) << sel_idx : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ST_RESET;
            push_cnt <= 2'd0;
            sel_nmi  <= 1'b0;
            sel_trap <= 1'b0;
            sel_idx  <= 4'h0;
        end else begin
            unique case (state)
                ST_RESET: state <= ST_RUN;
                ST_RUN: begin
                    if ((cpu_cmd.instr_end || halted) && win_valid) begin
                        state    <= ST_PUSH;
                        push_cnt <= 2'd0;
                        sel_nmi  <= win_nmi;
                        sel_trap <= win_trap;
                        sel_idx  <= win_idx;
                    end
                end
                ST_PUSH: begin
                    push_cnt <= push_cnt + 2'd1;
                    if (push_cnt == 2'(PUSH_BYTES - 1)) begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: state <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take    <= '0;
            src_ack <= '0;
        end else begin
            take.push_stb  <= (state == ST_PUSH);
            take.push_step <= push_cnt;
            take.vec_stb   <= (state == ST_RESET) || take_now;
            take.vec_idx   <= sel_idx;
            src_ack        <= ack_now;
            if (state == ST_RESET) begin
                take.vec_addr <= VEC_RESET;
            end else if (sel_trap) begin
                take.vec_addr <= VEC_TRAP;
            end else begin
                take.vec_addr <= pair_vec(sel_idx);
            end
        end
    end

    // ****************************************
    // halt tracking
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halted    <= 1'b0;
            halt_wake <= 1'b0;
        end else begin
            halt_wake <= halted && win_valid && (state == ST_RUN);
            if (take_now) begin
                halted <= 1'b0;
            end else if (cpu_cmd.halt && cpu_cmd.instr_end) begin
                halted <= 1'b1;
            end
        end
    end

    // ****************************************
    // condition code
    // ****************************************
    always_comb begin
        next_cc = condition_code;
        if (take_now) begin
            if (sel_nmi) begin
                next_cc[CC_I1] = LVL3[1];
                next_cc[CC_I0] = LVL3[0];
            end else begin
                next_cc[CC_I1] = pairs[2*sel_idx + 1];
                next_cc[CC_I0] = pairs[2*sel_idx];
            end
        end else if (cc_we) begin
            next_cc = pwdata[7:0] | CC_ONES;
        end else if (cpu_cmd.instr_end) begin
            if (cpu_cmd.pop_flags_instr || cpu_cmd.irq_return_instr) begin
                next_cc = cpu_cmd.data | CC_ONES;
            end else begin
                if (cpu_cmd.flags_we) begin
                    next_cc = (condition_code & ~CC_FLAG_MASK) | (cpu_cmd.data & CC_FLAG_MASK);
                end
                if (cpu_cmd.sim || cpu_cmd.trap) begin
                    next_cc[CC_I1] = LVL3[1];
                    next_cc[CC_I0] = LVL3[0];
                end else if (cpu_cmd.irq_enable_instr || cpu_cmd.halt || cpu_cmd.wait_for_irq_instr) begin
                    next_cc[CC_I1] = LVL0[1];
                    next_cc[CC_I0] = LVL0[0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            condition_code <= CC_RST;
        end else begin
            condition_code <= next_cc;
        end
    end

endmodule

// ---- rtl/nip_pkg.sv ----
/*
 * shared constants, types and helpers of the nested interrupt priority block.
 * assumes one clock domain (pclk) and a byte-wide CPU condition code.
 */
package nip_pkg;

    // ****************************************
    // sizes and register indices
    // ****************************************
    localparam int         NUM_PAIRS = 14;
    localparam int         PUSH_BYTES = 4;
    localparam logic [7:0] IDX_PRIO0 = 8'h2c;
    localparam logic [7:0] IDX_PRIO1 = 8'h2d;
    localparam logic [7:0] IDX_PRIO2 = 8'h2e;
    localparam logic [7:0] IDX_PRIO3 = 8'h2f;
    localparam logic [7:0] IDX_CC    = 8'h30;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [7:0] PRIO_RST     = 8'hff;
    localparam logic [7:0] PRIO3_RO     = 8'hf0;
    localparam logic [7:0] CC_RST       = 8'hea;
    localparam logic [7:0] CC_FLAG_MASK = 8'h17;
    localparam logic [7:0] CC_ONES      = 8'hc0;
    localparam int         CC_I1        = 5;
    localparam int         CC_I0        = 3;

    // ****************************************
    // priority codes {high bit, low bit}
    // ****************************************
    localparam logic [1:0] LVL0 = 2'b10;
    localparam logic [1:0] LVL1 = 2'b01;
    localparam logic [1:0] LVL2 = 2'b00;
    localparam logic [1:0] LVL3 = 2'b11;

    // ****************************************
    // vectors and halt exit capability
    // ****************************************
    localparam logic [15:0]          VEC_RESET = 16'hfffe;
    localparam logic [15:0]          VEC_TRAP  = 16'hfffc;
    localparam logic [15:0]          VEC_BASE  = 16'hfffa;
    localparam logic [NUM_PAIRS-1:0] WAKE_MASK = 14'h0667;

    typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_PUSH, ST_FETCH} nip_state_t;

    typedef struct packed {
        logic       instr_end;
        logic       irq_enable_instr;
        logic       sim;
        logic       halt;
        logic       wait_for_irq_instr;
        logic       trap;
        logic       pop_flags_instr;
        logic       irq_return_instr;
        logic       flags_we;
        logic [7:0] data;
    } nip_cpu_cmd_t;

    typedef struct packed {
        logic        push_stb;
        logic [1:0]  push_step;
        logic        vec_stb;
        logic [15:0] vec_addr;
        logic [3:0]  vec_idx;
    } nip_take_t;

    // level code to rank, 0 lowest
    function automatic logic [1:0] lvl_rank(input logic [1:0] code);
        unique case (code)
            LVL0: lvl_rank = 2'd0;
            LVL1: lvl_rank = 2'd1;
            LVL2: lvl_rank = 2'd2;
            LVL3: lvl_rank = 2'd3;
        endcase
    endfunction

    // vector address of a pair slot
    function automatic logic [15:0] pair_vec(input logic [3:0] idx);
        pair_vec = VEC_BASE - {11'h000, idx, 1'b0};
    endfunction

    // byte address of a register index
    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction

endpackage

// ---- rtl/nip_prio_regs.sv ----
/*
 * the four vector priority registers with per-pair write filtering.
 * assumes write strobe and index come decoded from the bus slave.
 */
`timescale 1ns/1ps
module nip_prio_regs
    import nip_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   wr_en,
    input  wire logic [1:0]             wr_idx,
    input  wire logic [7:0]             wr_data,
    output logic      [4*8-1:0]         regs
);

    // ****************************************
    // storage
    // ****************************************
    logic [7:0] bank [4];

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw);
        logic [7:0] res;
        res = old;
        for (int p = 0; p < 4; p++) begin
            if (nw[2*p +: 2] != LVL0) begin
                res[2*p +: 2] = nw[2*p +: 2];
            end
        end
        merge = res;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int r = 0; r < 4; r++) begin
                bank[r] <= PRIO_RST;
            end
        end else if (wr_en) begin
            bank[wr_idx] <= merge(bank[wr_idx], wr_data);
        end
    end

    always_comb begin
        regs = {bank[3] | PRIO3_RO, bank[2], bank[1], bank[0]};
    end

endmodule

// ---- rtl/nip_arbiter.sv ----
/*
 * picks the request to service from pending sources and current level.
 * assumes pending latches and enables are held by the caller.
 */
`timescale 1ns/1ps
module nip_arbiter
    import nip_pkg::*;
#(
    parameter int N = NUM_PAIRS
)
(
    input  wire logic [1:0]             cur_lvl,
    input  wire logic [N-1:0]           pend,
    input  wire logic [N-1:0]           enable,
    input  wire logic [2*N-1:0]         pairs,
    input  wire logic                   halted,
    input  wire logic                   trap_pend,
    output logic                        win_valid,
    output logic                        win_nmi,
    output logic                        win_trap,
    output logic [3:0]                  win_idx
);

    // wake mask and slot index only cover the documented pair count
    if (N < 2 || N > NUM_PAIRS) begin
        $error("nip_arbiter: pair count out of range");
    end

    logic [1:0] best;
    logic       found;
    logic       elig;

    always_comb begin
        best      = 2'd0;
        found     = 1'b0;
        elig      = 1'b0;
        win_idx   = 4'h0;
        win_nmi   = 1'b0;
        win_trap  = 1'b0;
        // walk from lowest hardware priority so lower slots win ties
        for (int i = N - 1; i >= 1; i--) begin
            elig = pend[i] && enable[i] && (!halted || WAKE_MASK[i]);
            if (elig && lvl_rank(pairs[2*i +: 2]) > lvl_rank(cur_lvl)) begin
                if (!found || lvl_rank(pairs[2*i +: 2]) >= best) begin
                    best    = lvl_rank(pairs[2*i +: 2]);
                    found   = 1'b1;
                    win_idx = 4'(i);
                end
            end
        end
        if (trap_pend) begin
            found    = 1'b1;
            win_trap = 1'b1;
            win_nmi  = 1'b1;
            win_idx  = 4'h0;
        end else if (pend[0]) begin
            found   = 1'b1;
            win_nmi = 1'b1;
            win_idx = 4'h0;
        end
        win_valid = found;
    end

endmodule

// ---- verification/nip_top_monitor.sv ----
/* checker of the nip_top ports: apb timing, level loads, entry order.
   assumes it is bound to nip_top, single clock pclk. */
`timescale 1ns/1ps
module nip_top_monitor
    import nip_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire nip_cpu_cmd_t         cpu_cmd,
    input wire logic [7:0]           condition_code,
    input wire nip_take_t            take,
    input wire logic                 halted,
    input wire logic [NUM_PAIRS-1:0] src_ack
);
    logic       mapped;
    logic       cmd_ok;
    logic       busy;
    logic [1:0] lvl;
    assign mapped = paddr inside {8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hc0};
    assign lvl    = {condition_code[5], condition_code[3]};
    // fetch cycle (last push step standing) and cc bus write beat cpu commands
    assign busy   = (take.push_stb && take.push_step == 2'd3)
                    || (psel && penable && pready && pwrite && paddr == 8'hc0);
    assign cmd_ok = cpu_cmd.instr_end && !busy && !cpu_cmd.pop_flags_instr && !cpu_cmd.irq_return_instr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********
    // sequences
    // ********
    sequence s_push_rest;
        take.push_stb && take.push_step == 2'd1 ##1 take.push_stb && take.push_step == 2'd2
            ##1 take.push_stb && take.push_step == 2'd3;
    endsequence
    a_pready_timing: assert property ((psel && !penable) |=> pready) else $error("pready late");
    a_pready_once: assert property (pready |=> !pready) else $error("pready too long");
    a_map_err: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
    a_read_pad: assert property ((pready && !pwrite) |-> prdata[31:8] == 24'h0) else $error("read pad");
    a_cc_ones: assert property (condition_code[7:6] == 2'b11) else $error("cc top bits");
    a_rim_load: assert property ((cmd_ok && cpu_cmd.irq_enable_instr && !cpu_cmd.sim && !cpu_cmd.trap) |=> lvl == LVL0)
        else $error("rim level");
    a_sim_load: assert property ((cmd_ok && cpu_cmd.sim) |=> lvl == LVL3) else $error("sim level");
    a_halt_load: assert property ((cmd_ok && (cpu_cmd.halt || cpu_cmd.wait_for_irq_instr) && !cpu_cmd.sim && !cpu_cmd.trap)
        |=> lvl == LVL0) else $error("halt level");
    a_pop_load: assert property ((cpu_cmd.instr_end && (cpu_cmd.pop_flags_instr || cpu_cmd.irq_return_instr) && !busy)
        |=> condition_code == ($past(cpu_cmd.data) | CC_ONES)) else $error("pop level");
    a_push_order: assert property ((take.push_stb && take.push_step == 2'd0) |=> s_push_rest ##1 take.vec_stb)
        else $error("push order");
    a_nmi_level: assert property ((take.vec_stb && take.vec_addr >= VEC_BASE) |=> lvl == LVL3)
        else $error("nmi level");
    a_ack_slot: assert property ((|src_ack) |-> take.vec_stb && $onehot(src_ack) && src_ack[take.vec_idx]
        && take.vec_addr == 16'hfffa - {11'h0, take.vec_idx, 1'b0}) else $error("ack slot");
    a_wake_slot: assert property ((take.vec_stb && (|src_ack) && $past(halted))
        |-> take.vec_idx inside {4'd0, 4'd1, 4'd2, 4'd5, 4'd6, 4'd9, 4'd10}) else $error("wake slot");
endmodule

bind nip_top nip_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_cmd(cpu_cmd), .condition_code(condition_code), .take(take), .halted(halted), .src_ack(src_ack));

// ---- verification/nip_cpu_model.sv ----
/* cpu core and peripheral model: ends an instruction every cycle,
   relays commands and source pulses. assumes bench drives op and irq. */
`timescale 1ns/1ps
module nip_cpu_model
    import nip_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire nip_cpu_cmd_t         op,
    input  wire logic [NUM_PAIRS-1:0] irq,
    output nip_cpu_cmd_t              cpu_cmd,
    output logic [NUM_PAIRS-1:0]      src_set
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_cmd <= '0;
            src_set <= '0;
        end else begin
            cpu_cmd           <= op;
            cpu_cmd.instr_end <= 1'b1;
            src_set           <= irq;
        end
    end
endmodule

// ---- verification/nested_interrupt_priority_test.sv ----
/* self-checking bench of nip_top with a shadow register model.
   assumes the cpu model ends an instruction every cycle. */
`timescale 1ns/1ps
module nested_interrupt_priority_test
    import nip_pkg::*;
;
    logic                 pclk, presetn, psel, penable, pwrite, tli_pin, pready, pslverr, halted, halt_wake, e;
    logic [7:0]           paddr, condition_code;
    logic [31:0]          pwdata, prdata, r;
    logic [1:0]           lvl;
    logic [NUM_PAIRS-1:0] irq, src_set, src_enable, src_ack;
    nip_cpu_cmd_t         op, cpu_cmd;
    nip_take_t            take;
    int                   n_fail, checked, seed, i;
    int                   prio[4];
    int                   ks[5] = '{1, 2, 3, 2, 4};
    assign lvl = {condition_code[5], condition_code[3]};
    nip_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .op(op), .irq(irq), .cpu_cmd(cpu_cmd), .src_set(src_set));
    nip_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_cmd(cpu_cmd), .tli_pin(tli_pin),
        .src_set(src_set), .src_clr('0), .src_enable(src_enable), .condition_code(condition_code), .take(take),
        .src_ack(src_ack), .halted(halted), .halt_wake(halt_wake));
    // ********
    // tasks
    // ********
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin chk(0, 1); report_and_stop(); end
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input int j, input logic [7:0] d);
        logic [7:0] v;
        v = 8'(prio[j]);
        for (int k = 0; k < 4; k++)
            if (d[2*k+:2] != 2'b10) v[2*k+:2] = d[2*k+:2];
        if (j == 3) v[7:4] = 4'hf;
        prio[j] = v;
        apb(1'b1, 8'(8'hb0 + 4*j), {24'h0, d});
    endtask
    task automatic rd(input int j);
        apb(1'b0, 8'(8'hb0 + 4*j), 32'h0);
        chk(r, prio[j]);
    endtask
    task automatic cmd(input int k, input logic [7:0] d);
        nip_cpu_cmd_t o;
        o = '0; o.irq_enable_instr = k == 1; o.sim = k == 2; o.halt = k == 3; o.wait_for_irq_instr = k == 4; o.trap = k == 5;
        o.pop_flags_instr = k == 6; o.irq_return_instr = k == 7; o.data = d;
        op <= o;
        @(posedge pclk);
        op <= '0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic pulse(input int s);
        irq <= NUM_PAIRS'(1) << s;
        @(posedge pclk);
        irq <= '0;
    endtask
    task automatic no_vec(input int n);
        repeat (n) begin @(posedge pclk); chk(take.vec_stb, 0); end
    endtask
    task automatic wait_vec(input logic [15:0] a, input logic [1:0] l, input logic [NUM_PAIRS-1:0] ack);
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge pclk);
            if (take.vec_stb === 1'b1) break;
        end
        if (k == 40) begin chk(0, 1); report_and_stop(); end
        chk(take.vec_addr, a);
        chk(src_ack, ack);
        @(posedge pclk);
        chk(lvl, l);
    endtask
    // ********
    // stimulus
    // ********
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; op = '0; tli_pin = 0;
        irq = '0; src_enable = '1; n_fail = 0; checked = 0; seed = 13;
        for (i = 0; i < 4; i++) prio[i] = 255;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(posedge pclk); chk({take.vec_stb, take.vec_addr}, 17'h1fffe);
        for (i = 0; i < 4; i++) rd(i);
        apb(1'b0, 8'hc0, 32'h0); chk(r, 32'hea);
        apb(1'b1, 8'hc0, 32'h15); apb(1'b0, 8'hc0, 32'h0); chk(r, 32'hd5);
        apb(1'b0, 8'h10, 32'h0); chk({r[30:0], e}, 32'h1);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin wr(i % 4, 8'($random(seed))); rd(i % 4); end
        wr(1, 8'haa); rd(1);
        $display("test priority regs done");
        for (i = 0; i < 5; i++) begin cmd(ks[i], 8'h0); chk(lvl, (ks[i] == 2) ? 2'b11 : 2'b10); end
        $display("test commands done");
        cmd(5, 8'h0); wait_vec(VEC_TRAP, 2'b11, '0);
        tli_pin <= 1'b1; wait_vec(16'hfffa, 2'b11, 14'h1); tli_pin <= 1'b0;
        $display("test nmi done");
        wr(0, 8'h7f); wr(1, 8'hfd);
        pulse(3); no_vec(20);
        cmd(1, 8'h0); wait_vec(16'hfff4, 2'b01, 14'h8);
        pulse(4); no_vec(20);
        cmd(6, 8'he2); chk(condition_code, 8'he2);
        wait_vec(16'hfff2, 2'b01, 14'h10);
        $display("test maskable done");
        cmd(3, 8'h0); pulse(3); no_vec(20); chk({halted, halt_wake}, 2'b10);
        pulse(5); wait_vec(16'hfff0, 2'b11, 14'h20); chk(halted, 0);
        src_enable[3] <= 1'b0; cmd(7, 8'he2); chk(condition_code, 8'he2); no_vec(10);
        src_enable <= '1; wait_vec(16'hfff4, 2'b01, 14'h8);
        $display("test halt done");
        report_and_stop();
    end
endmodule
